// ### hdl/vc1_consts.svh
// Offsets, field positions, reset values and counts for the channel pair
`ifndef VC1_CONSTS_SVH
`define VC1_CONSTS_SVH
`define VC1_CAP_OFFSET 12'h21C
`define VC1_CTL_OFFSET 12'h220
`define VC1_STS_OFFSET 12'h224
`define CAP_ARB_RESET 8'h01
`define CAP_OFFSET_RESET 8'h00
`define CTL_TC_MAP_RESET 8'h00
`define CTL_SEL_RESET 3'h0
`define CTL_ID_RESET 3'h1
`define CTL_EN_RESET 1'h0
`define CTL_LOAD_BIT 16
`define CTL_SEL_LSB 17
`define CTL_ID_LSB 24
`define CTL_EN_BIT 31
`define STS_TABLE_BIT 16
`define STS_NEG_BIT 17
`define LOAD_CYCLES 4'h4
`endif

// ### hdl/vc1_pkg.sv
// Types shared by the channel register pair
package vc1_pkg;
    // Load sequencer states, one-hot
    typedef enum logic [1:0]
    {
        LOAD_IDLE = 2'b01,
        LOAD_BUSY = 2'b10
    } load_state_t;
endpackage

// ### hdl/vc1_table_loader.sv
// Sequencer that copies the arbitration table into the arbiter
`timescale 1ns/1ps
`include "vc1_consts.svh"
module vc1_table_loader
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic load_start,
    output logic load_active,
    output logic load_done
);
    // Current state and beat counter
    vc1_pkg::load_state_t state;
    logic [3:0] count;

    // Walk fixed number of cycles while the arbiter latches entries
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= vc1_pkg::LOAD_IDLE;
            count <= 4'h0;
            load_done <= 1'b0;
        end
        else
        begin
            load_done <= 1'b0;
            case (state)
                vc1_pkg::LOAD_IDLE:
                begin
                    // A new start is the only way out of idle
                    if (load_start)
                    begin
                        state <= vc1_pkg::LOAD_BUSY;
                        count <= `LOAD_CYCLES;
                    end
                end
                vc1_pkg::LOAD_BUSY:
                begin
                    // Final beat raises done for one cycle
                    if (count == 4'h1)
                    begin
                        state <= vc1_pkg::LOAD_IDLE;
                        load_done <= 1'b1;
                    end
                    count <= count - 4'h1;
                end
                default:
                    state <= vc1_pkg::LOAD_IDLE;
            endcase
        end
    end

    // Copy strobe to the arbiter is held across the busy window
    assign load_active = (state == vc1_pkg::LOAD_BUSY);
endmodule

// ### hdl/vc1_tc_router.sv
// Traffic class to channel steering
`timescale 1ns/1ps
`include "vc1_consts.svh"
module vc1_tc_router
(
    input wire logic [7:0] traffic_class_map,
    input wire logic channel_enable,
    input wire logic [2:0] packet_tc,
    output logic packet_to_vc1
);
    // Steer a packet here when its class bit is set and channel is on
    assign packet_to_vc1 = channel_enable
        & traffic_class_map[packet_tc];
endmodule

// ### hdl/vc1_config_regs.sv
// Capability and control registers for virtual channel resource 1
`timescale 1ns/1ps
`include "vc1_consts.svh"
// What this block does
// - Arbitration capability resets to 0x1, bit0
// - Several capability bits may be set
// - Advanced packet switching bit reads zero
// - Reject snoop bit reads zero
// - Maximum time slots field reads zero
// - Table offset in 16-byte units, resets zero
// - Class map resets zero, bit0 read-only
// - Set class bit routes class here while enable bit is set
// - Writing load bit copies table to arbiter
// - Writing zero to load does nothing
// - Load bit always reads zero
// - Load acts only if scheme uses table
// - Channel identifier writable, resets to 0x1
// - Enable bit writable, resets zero
// - Table status sets on entry write
// - Status bit 17 shows negotiation pending
module vc1_config_regs
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [11:0] cfg_addr,
    input wire logic cfg_write,
    input wire logic cfg_read,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    input wire logic cap_unlock,
    input wire logic [7:0] table_uses_mask,
    input wire logic table_entry_written,
    input wire logic negotiation_pending,
    input wire logic [2:0] packet_tc,
    output logic packet_to_vc1,
    output logic arb_table_copy,
    output logic channel_enable,
    output logic [2:0] channel_identifier,
    output logic [7:0] traffic_class_map,
    output logic [2:0] arb_scheme_select,
    output logic [7:0] arb_table_offset
);
    // Capability fields that only an unlocked write may change
    logic [7:0] arb_capability_mask;
    // Table coherency flag
    logic arb_table_status;
    // Decoded accesses
    logic cap_wr;
    logic ctl_wr;
    logic arb_table_load;
    logic load_active;
    logic load_done;

    // Byte lane write merge used by the two capability register bytes
    function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
        input logic [7:0] new_v, input logic en);
        merge_byte = en ? new_v : old_v;
    endfunction

    // Whether the chosen scheme's capability bit marks a table user
    function automatic logic scheme_uses_table(input logic [2:0] sel,
        input logic [7:0] cap, input logic [7:0] uses);
        scheme_uses_table = cap[sel] & uses[sel];
    endfunction

    assign cap_wr = cfg_write & (cfg_addr == `VC1_CAP_OFFSET);
    assign ctl_wr = cfg_write & (cfg_addr == `VC1_CTL_OFFSET);

    // Capability register, lockable bytes 0 and 3 only
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            arb_capability_mask <= `CAP_ARB_RESET;
            arb_table_offset <= `CAP_OFFSET_RESET;
        end
        else if (cap_wr && cap_unlock)
        begin
            // Whole byte so several schemes can be advertised
            arb_capability_mask <= merge_byte(arb_capability_mask,
                cfg_wdata[7:0], cfg_byte_en[0]);
            arb_table_offset <= merge_byte(arb_table_offset,
                cfg_wdata[31:24], cfg_byte_en[3]);
        end
    end

    // Class map; bit 0 stays at its reset value
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            traffic_class_map <= `CTL_TC_MAP_RESET;
        else if (ctl_wr && cfg_byte_en[0])
            traffic_class_map <= {cfg_wdata[7:1],
                traffic_class_map[0]};
    end

    // Scheme select; software keeps it to advertised values
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            arb_scheme_select <= `CTL_SEL_RESET;
        else if (ctl_wr && cfg_byte_en[2])
            arb_scheme_select <= cfg_wdata[`CTL_SEL_LSB +: 3];
    end

    // Identifier and enable in the top byte
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            channel_identifier <= `CTL_ID_RESET;
            channel_enable <= `CTL_EN_RESET;
        end
        else if (ctl_wr && cfg_byte_en[3])
        begin
            channel_identifier <= cfg_wdata[`CTL_ID_LSB +: 3];
            channel_enable <= cfg_wdata[`CTL_EN_BIT];
        end
    end

    // Load request is a write strobe, never stored, so zero is inert
    assign arb_table_load = ctl_wr & cfg_byte_en[2]
        & cfg_wdata[`CTL_LOAD_BIT]
        & scheme_uses_table(arb_scheme_select, arb_capability_mask,
            table_uses_mask);

    // Sequencer holds the copy strobe toward the arbiter
    vc1_table_loader loader
    (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load_start(arb_table_load),
        .load_active(load_active),
        .load_done(load_done)
    );
    assign arb_table_copy = load_active;

    // Table status: an entry write wins over a finishing load
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            arb_table_status <= 1'b0;
        else if (table_entry_written)
            arb_table_status <= 1'b1;
        else if (load_done)
            arb_table_status <= 1'b0;
    end

    // Class steering for the data path
    vc1_tc_router router
    (
        .traffic_class_map(traffic_class_map),
        .channel_enable(channel_enable),
        .packet_tc(packet_tc),
        .packet_to_vc1(packet_to_vc1)
    );

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cfg_rdata <= 32'h00000000;
        else if (cfg_read)
        begin
            case (cfg_addr)
                `VC1_CAP_OFFSET:
                    // ADV_PACKET_SWITCHING, snoop reject, time slots hard zero
                    cfg_rdata <= {arb_table_offset, 1'b0, 7'h00,
                        1'b0, 1'b0, 6'h00,
                        arb_capability_mask};
                `VC1_CTL_OFFSET:
                    // Load bit always returns zero
                    cfg_rdata <= {channel_enable, 4'h0,
                        channel_identifier, 4'h0, arb_scheme_select,
                        1'b0, 8'h00, traffic_class_map};
                `VC1_STS_OFFSET:
                    cfg_rdata <= {14'h0000, negotiation_pending,
                        arb_table_status, 16'h0000};
                default:
                    cfg_rdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// ### bench/vc1_props.sv
// Port checks for the channel register pair
`timescale 1ns/1ps
`include "vc1_consts.svh"
module vc1_props
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [11:0] cfg_addr,
    input wire logic cfg_write,
    input wire logic cfg_read,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic [7:0] traffic_class_map,
    input wire logic channel_enable,
    input wire logic [2:0] packet_tc,
    input wire logic packet_to_vc1,
    input wire logic arb_table_copy,
    input wire logic [2:0] channel_identifier
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Decoded accesses
    wire ctl_wr = cfg_write && cfg_addr == `VC1_CTL_OFFSET;
    wire ctl_rd = cfg_read && cfg_addr == `VC1_CTL_OFFSET;
    wire cap_rd = cfg_read && cfg_addr == `VC1_CAP_OFFSET;
    a_map_bit_zero: assert property (!traffic_class_map[0])
        else $error("class map bit 0 set");
    a_class_route: assert property
        (packet_to_vc1 == (channel_enable && traffic_class_map[packet_tc]))
        else $error("class steering wrong");
    a_copy_four: assert property
        ($rose(arb_table_copy) |-> arb_table_copy[*4] ##1 !arb_table_copy)
        else $error("table copy not four cycles");
    a_load_reads_zero: assert property (ctl_rd |=> !cfg_rdata[16])
        else $error("load bit read as one");
    a_cap_fixed_zero: assert property
        (cap_rd |=> cfg_rdata[23:8] == 16'h0000)
        else $error("fixed capability bits not zero");
    a_ctl_reserved: assert property (ctl_rd |=> cfg_rdata[15:8] == 8'h00
        && cfg_rdata[23:20] == 4'h0 && cfg_rdata[30:27] == 4'h0)
        else $error("reserved control bits not zero");
    // Guard against a load launched just before
    a_zero_no_load: assert property (ctl_wr && cfg_byte_en[2]
        && !cfg_wdata[16] && !arb_table_copy && !$past(cfg_write)
        |=> !arb_table_copy)
        else $error("zero load write started copy");
    a_id_follows: assert property (ctl_wr && cfg_byte_en[3]
        |=> channel_identifier == $past(cfg_wdata[26:24]))
        else $error("identifier not written");
    a_enable_follows: assert property (ctl_wr && cfg_byte_en[3]
        |=> channel_enable == $past(cfg_wdata[31]))
        else $error("enable not written");
endmodule

// ### bench/testbench.sv
// Self-checking bench for the channel register pair
`timescale 1ns/1ps
`include "vc1_consts.svh"
module testbench;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] cfg_addr = 12'h000;
    logic cfg_write = 1'b0;
    logic cfg_read = 1'b0;
    logic [3:0] cfg_byte_en = 4'h0;
    logic [31:0] cfg_wdata = 32'h00000000;
    logic [31:0] cfg_rdata;
    logic cap_unlock = 1'b0;
    logic [7:0] table_uses_mask = 8'h00;
    logic table_entry_written = 1'b0;
    logic negotiation_pending = 1'b0;
    logic [2:0] packet_tc = 3'h0;
    logic packet_to_vc1, arb_table_copy, channel_enable;
    logic [2:0] channel_identifier, arb_scheme_select;
    logic [7:0] traffic_class_map, arb_table_offset;
    int failures = 0;
    int tests_run = 0;
    // 125 MHz core clock
    always #4 core_clk = ~core_clk;
    vc1_config_regs vc1_config_regs_inst (.core_clk, .sys_rst, .cfg_addr,
        .cfg_write, .cfg_read, .cfg_byte_en, .cfg_wdata, .cfg_rdata,
        .cap_unlock, .table_uses_mask, .table_entry_written,
        .negotiation_pending, .packet_tc, .packet_to_vc1, .arb_table_copy,
        .channel_enable, .channel_identifier, .traffic_class_map,
        .arb_scheme_select, .arb_table_offset);
    // Compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One write, held across one rising edge
    task automatic wr(input logic [11:0] a, input logic [3:0] b,
        input logic [31:0] d);
        @(negedge core_clk);
        cfg_addr = a;
        cfg_byte_en = b;
        cfg_wdata = d;
        cfg_write = 1'b1;
        @(negedge core_clk);
        cfg_write = 1'b0;
    endtask
    // Read data is registered, so compare a cycle later
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(negedge core_clk);
        cfg_addr = a;
        cfg_read = 1'b1;
        @(negedge core_clk);
        cfg_read = 1'b0;
        chk(cfg_rdata, e);
    endtask
    // Count copy cycles over a window wider than one load
    task automatic copies(input int e);
        int n;
        n = 0;
        repeat (8)
        begin
            if (arb_table_copy === 1'b1)
                n++;
            @(negedge core_clk);
        end
        chk(n, e);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        rd(`VC1_CAP_OFFSET, 32'h00000001);
        rd(`VC1_CTL_OFFSET, 32'h01000000);
        rd(`VC1_STS_OFFSET, 32'h00000000);
        rd(12'h300, 32'h00000000);
        $display("reset test done");
        wr(`VC1_CAP_OFFSET, 4'hF, 32'hFFFFFFFF);
        rd(`VC1_CAP_OFFSET, 32'h00000001);
        cap_unlock = 1'b1;
        wr(`VC1_CAP_OFFSET, 4'hF, 32'hFFFFFF03);
        rd(`VC1_CAP_OFFSET, 32'hFF000003);
        chk({24'h0, arb_table_offset}, 32'h000000FF);
        $display("capability test done");
        // Scheme 1 chosen while no scheme uses the table
        wr(`VC1_CTL_OFFSET, 4'hF, 32'hFDF3FFFF);
        copies(0);
        chk({29'h0, arb_scheme_select}, 32'h00000001);
        rd(`VC1_CTL_OFFSET, 32'h850200FE);
        table_uses_mask = 8'h02;
        table_entry_written = 1'b1;
        @(negedge core_clk);
        table_entry_written = 1'b0;
        rd(`VC1_STS_OFFSET, 32'h00010000);
        wr(`VC1_CTL_OFFSET, 4'h4, 32'h00030000);
        copies(4);
        rd(`VC1_STS_OFFSET, 32'h00000000);
        wr(`VC1_CTL_OFFSET, 4'h4, 32'h00020000);
        copies(0);
        negotiation_pending = 1'b1;
        rd(`VC1_STS_OFFSET, 32'h00020000);
        $display("load test done");
        for (int t = 0; t < 8; t++)
        begin
            @(negedge core_clk);
            packet_tc = t[2:0];
            #1 chk({31'h0, packet_to_vc1}, {31'h0, t != 0});
        end
        wr(`VC1_CTL_OFFSET, 4'h8, 32'h00000000);
        chk({31'h0, packet_to_vc1}, 32'h0);
        rd(`VC1_CTL_OFFSET, 32'h000200FE);
        $display("steering test done");
        end_sim();
    end
    // Watchdog well beyond the roughly 70 cycles the tests need
    initial
    begin
        #20000;
        failures++;
        end_sim();
    end
endmodule
bind vc1_config_regs vc1_props vc1_props_inst (.core_clk, .sys_rst,
    .cfg_addr, .cfg_write, .cfg_read, .cfg_byte_en, .cfg_wdata, .cfg_rdata,
    .traffic_class_map, .channel_enable, .packet_tc, .packet_to_vc1,
    .arb_table_copy, .channel_identifier);
